/* File: src/data_space_pkg.sv */
// shared constants and types for the data-space access unit
package data_space_pkg;

  // ****************************************
  // address map
  // ****************************************
  localparam logic [15:0] RAM_BASE   = 16'h0800;
  localparam logic [15:0] Y_BASE     = 16'h0860;
  localparam logic [15:0] Y_LAST     = 16'h087F;
  localparam logic [15:0] SP_FLOOR   = 16'h0800;
  localparam logic [15:0] NEAR_LAST  = 16'h1FFF;
  localparam int          NEAR_BITS  = 13;
  localparam int          MEM_WORDS_DEF = 64;
  localparam int          BITREV_BITS   = 4;

  // ****************************************
  // steps and register indices
  // ****************************************
  localparam logic [15:0] BYTE_STEP   = 16'h0001;
  localparam logic [15:0] WORD_STEP   = 16'h0002;
  localparam logic [3:0]  X_PTR_A_IDX = 4'h8;
  localparam logic [3:0]  Y_PTR_A_IDX = 4'hA;
  localparam logic [3:0]  SP_IDX      = 4'hF;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;

  // ****************************************
  // request encodings
  // ****************************************
  typedef enum logic [2:0] {
    OP_READ  = 3'b000,
    OP_WRITE = 3'b001,
    OP_MAC   = 3'b011,
    OP_PUSH  = 3'b010,
    OP_POP   = 3'b110,
    OP_LIMIT = 3'b111
  } op_t;

  typedef enum logic [1:0] {
    MODE_IND  = 2'b00,
    MODE_NEAR = 2'b01,
    MODE_ABS  = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    PUSH_PLAIN = 2'b00,
    PUSH_CALL  = 2'b01,
    PUSH_EXC   = 2'b11
  } push_kind_t;

endpackage

/* File: src/stack_guard.sv */
// stack limit register and stack overflow / underflow detection
`timescale 1ns/100ps
`default_nettype none

module stack_guard
  import data_space_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sp_used,
  input  wire logic        sp_push,
  input  wire logic [15:0] sp_addr,
  input  wire logic        limit_we,
  input  wire logic [15:0] limit_wdata,
  output logic             stack_fault,
  output logic [15:0]      stack_limit
);

  logic [15:1] limit_hi;
  wire  logic  over_limit;
  wire  logic  under_floor;

  // ****************************************
  // limit register, no reset on purpose
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (limit_we) begin
      limit_hi <= limit_wdata[15:1];
    end
  end

  assign stack_limit = {limit_hi, 1'b0};

  // a push at the limit itself is allowed, the one above it faults
  assign over_limit  = sp_push && (sp_addr > stack_limit);
  assign under_floor = sp_addr < SP_FLOOR;
  assign stack_fault = sp_used && (over_limit || under_floor);

endmodule

`default_nettype wire

/* File: src/data_space_access_stack_check.sv */
// data-space access unit: X/Y read paths, X write path, alignment and stack traps
// Functional notes
// - every data write, stack pushes included, goes over the X write path.
// - Y path only reads, as second operand path of multiply-accumulate ops.
// - bit-reversed addressing on X writes only; modulo wrapping on X and Y.
// - multiply-accumulate uses the two X pointers for X, two Y pointers for Y.
// - X/Y boundary is a fixed constant, not programmable.
// - unimplemented addresses read back as zero.
// - X pointer into Y space, or Y pointer into X space, reads zero.
// - addresses are 16-bit byte addresses over 16-bit words.
// - byte read selects byte by address bit 0, placed in low byte.
// - byte write enables only the matching byte lane.
// - post-increment steps by 1 for bytes, 2 for words.
// - misaligned word access traps; read completes, write suppressed.
// - byte loads change only the low half of the destination register.
// - near direct mode uses a 13-bit field, reaching 0 to 0x1FFF.
// - absolute mode uses a full 16-bit field across X space.
// - stack grows upward; push post-increments, pop pre-decrements.
// - call pushes clear the upper byte of the pushed word.
// - exception pushes put the status low byte in the upper byte.
// - stack limit is not reset and its bit 0 is always zero.
// - push above the limit traps; push exactly at the limit does not.
// - stack address below 0x0800 raises the stack error trap.
`timescale 1ns/100ps
`default_nettype none

module data_space_access_stack_check
  import data_space_pkg::*;
#(
  parameter int MEM_WORDS = MEM_WORDS_DEF
)(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        req_valid,
  input  wire op_t         req_op,
  input  wire mode_t       req_mode,
  input  wire logic        req_byte,
  input  wire logic [3:0]  req_ptr,
  input  wire logic        req_post_inc,
  input  wire logic        req_bitrev,
  input  wire logic [15:0] req_field,
  input  wire logic [3:0]  req_dest,
  input  wire logic        req_dest_en,
  input  wire logic [15:0] req_wdata,
  input  wire push_kind_t  req_push_kind,
  input  wire logic        req_x_sel,
  input  wire logic        req_y_sel,
  input  wire logic        mod_x_en,
  input  wire logic        mod_y_en,
  input  wire logic [15:0] mod_start,
  input  wire logic [15:0] mod_end,
  input  wire logic [7:0]  status_low_byte,
  input  wire logic        reg_we,
  input  wire logic [3:0]  reg_widx,
  input  wire logic [15:0] reg_wdata,
  input  wire logic [3:0]  reg_ridx,
  output logic [15:0]      reg_rdata,
  output logic             rsp_valid,
  output logic [15:0]      x_rdata,
  output logic [15:0]      y_rdata,
  output logic             addr_error_trap,
  output logic             stack_error_trap,
  output logic [15:0]      stack_limit
);

  localparam int          IDX_W    = $clog2(MEM_WORDS);
  localparam logic [15:0] RAM_LAST = 16'(32'(RAM_BASE) + 2 * MEM_WORDS - 1);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic is_impl(input logic [15:0] a);
    return (a >= RAM_BASE) && (a <= RAM_LAST);
  endfunction

  function automatic logic in_y(input logic [15:0] a);
    return (a >= Y_BASE) && (a <= Y_LAST);
  endfunction

  function automatic logic [IDX_W-1:0] mem_idx(input logic [15:0] a);
    logic [15:0] off;
    off = a - RAM_BASE;
    return off[IDX_W:1];
  endfunction

  function automatic logic [15:0] post_mod(input logic [15:0] p, input logic [15:0] step,
                                            input logic wrap);
    logic [15:0] sum;
    sum = p + step;
    return (wrap && sum > mod_end) ? mod_start : sum;
  endfunction

  function automatic logic [15:0] bit_rev(input logic [15:0] p);
    logic [15:0] r;
    r = p;
    for (int i = 0; i < BITREV_BITS; i++) begin
      r[i + 1] = p[BITREV_BITS - i];
    end
    return r;
  endfunction

  function automatic logic [15:0] read_word(input logic [15:0] a, input logic ok,
                                            input logic [15:0] w);
    return (ok && is_impl(a)) ? w : WORD_RESET;
  endfunction

  // ****************************************
  // storage
  // ****************************************
  logic [15:0] work_reg [16];
  logic [15:0] mem      [MEM_WORDS];

  // ****************************************
  // decode
  // ****************************************
  wire logic        is_read   = req_valid && (req_op == OP_READ);
  wire logic        is_write  = req_valid && (req_op == OP_WRITE);
  wire logic        is_mac    = req_valid && (req_op == OP_MAC);
  wire logic        is_push   = req_valid && (req_op == OP_PUSH);
  wire logic        is_pop    = req_valid && (req_op == OP_POP);
  wire logic        is_limit  = req_valid && (req_op == OP_LIMIT);
  wire logic        is_ind    = req_mode == MODE_IND;
  wire logic [15:0] ptr_val   = work_reg[req_ptr];
  wire logic [15:0] sp_val    = work_reg[SP_IDX];
  wire logic [15:0] sp_dec    = sp_val - WORD_STEP;
  wire logic [15:0] step      = req_byte ? BYTE_STEP : WORD_STEP;
  wire logic        ptr_wrap  = (mod_x_en && !in_y(ptr_val)) || (mod_y_en && in_y(ptr_val));
  wire logic [15:0] ind_addr  = (is_write && req_bitrev) ? bit_rev(ptr_val) : ptr_val;
  wire logic [15:0] near_addr = {{(16 - NEAR_BITS){1'b0}}, req_field[NEAR_BITS-1:0]};

  logic [15:0] eff_addr;
  always_comb begin
    case (req_mode)
      MODE_IND:  eff_addr = ind_addr;
      MODE_NEAR: eff_addr = near_addr;
      MODE_ABS:  eff_addr = req_field;
      default:   eff_addr = ind_addr;
    endcase
    if (is_push) begin
      eff_addr = sp_val;
    end else if (is_pop) begin
      eff_addr = sp_dec;
    end
  end

  // multiply-accumulate operand addresses from the dedicated pointers
  wire logic [3:0]  x_ptr_idx = X_PTR_A_IDX + {3'b000, req_x_sel};
  wire logic [3:0]  y_ptr_idx = Y_PTR_A_IDX + {3'b000, req_y_sel};
  wire logic [15:0] x_addr    = work_reg[x_ptr_idx];
  wire logic [15:0] y_addr    = work_reg[y_ptr_idx];

  // ****************************************
  // alignment and stack checks
  // ****************************************
  wire logic word_acc   = !req_byte || is_mac || is_push || is_pop;
  wire logic mis_single = (is_read || is_write || is_push || is_pop) && word_acc && eff_addr[0];
  wire logic mis_mac    = is_mac && (x_addr[0] || y_addr[0]);
  wire logic misaligned = mis_single || mis_mac;

  wire logic sp_ind   = (is_read || is_write) && is_ind && (req_ptr == SP_IDX);
  wire logic sp_used  = is_push || is_pop || sp_ind;
  wire logic sp_grows = is_push || (is_write && sp_ind && req_post_inc);
  wire logic stack_fault;

  stack_guard u_stack_guard (
    .core_clk    (core_clk),
    .sp_used     (sp_used),
    .sp_push     (sp_grows),
    .sp_addr     (eff_addr),
    .limit_we    (is_limit),
    .limit_wdata (req_wdata),
    .stack_fault (stack_fault),
    .stack_limit (stack_limit)
  );

  // ****************************************
  // read path
  // ****************************************
  wire logic [15:0] word_at  = mem[mem_idx(eff_addr)];
  wire logic [15:0] rd_word  = read_word(eff_addr, 1'b1, word_at);
  wire logic [7:0]  rd_byte  = eff_addr[0] ? rd_word[15:8] : rd_word[7:0];
  wire logic [15:0] rd_value = (req_byte && !is_pop) ? {ZERO_BYTE, rd_byte} : rd_word;
  wire logic [15:0] mac_x    = read_word(x_addr, !in_y(x_addr), mem[mem_idx(x_addr)]);
  wire logic [15:0] mac_y    = read_word(y_addr, in_y(y_addr), mem[mem_idx(y_addr)]);
  wire logic [15:0] next_x   = is_mac ? mac_x : rd_value;
  wire logic [15:0] next_y   = is_mac ? mac_y : WORD_RESET;

  // ****************************************
  // write path, X bus only
  // ****************************************
  logic [15:0] push_data;
  always_comb begin
    case (req_push_kind)
      PUSH_CALL: push_data = {ZERO_BYTE, req_wdata[7:0]};
      PUSH_EXC:  push_data = {status_low_byte, req_wdata[7:0]};
      default:   push_data = req_wdata;
    endcase
  end

  wire logic        byte_wr  = is_write && req_byte;
  wire logic [15:0] wr_data  = is_push ? push_data :
                               (byte_wr ? {req_wdata[7:0], req_wdata[7:0]} : req_wdata);
  wire logic        wr_go    = (is_write || is_push) && is_impl(eff_addr) && !misaligned;
  wire logic [1:0]  wr_lanes = byte_wr ? (eff_addr[0] ? 2'b10 : 2'b01) : 2'b11;
  wire logic [IDX_W-1:0] wr_idx = mem_idx(eff_addr);

  // ****************************************
  // working register updates
  // ****************************************
  wire logic        ptr_upd   = (is_read || is_write) && is_ind && req_post_inc;
  wire logic [15:0] ptr_next  = post_mod(ptr_val, step, ptr_wrap);
  wire logic [15:0] x_next    = post_mod(x_addr, WORD_STEP, mod_x_en);
  wire logic [15:0] y_next    = post_mod(y_addr, WORD_STEP, mod_y_en);
  wire logic        load_dest = (is_read || is_pop) && req_dest_en;
  wire logic [15:0] old_dest  = work_reg[req_dest];
  wire logic [15:0] dest_val  = (req_byte && !is_pop) ? {old_dest[15:8], rd_byte} : rd_word;
  wire logic        core_wr   = reg_we && !req_valid;

  assign reg_rdata = work_reg[reg_ridx];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        work_reg[i] <= WORD_RESET;
      end
    end else begin
      if (core_wr) begin
        work_reg[reg_widx] <= (reg_widx == SP_IDX) ? {reg_wdata[15:1], 1'b0} : reg_wdata;
      end
      if (ptr_upd) begin
        work_reg[req_ptr] <= ptr_next;
      end
      if (is_mac && req_post_inc) begin
        work_reg[x_ptr_idx] <= x_next;
        work_reg[y_ptr_idx] <= y_next;
      end
      if (is_push) begin
        work_reg[SP_IDX] <= sp_val + WORD_STEP;
      end
      if (is_pop) begin
        work_reg[SP_IDX] <= sp_dec;
      end
      if (load_dest) begin
        work_reg[req_dest] <= dest_val;
      end
    end
  end

  // ****************************************
  // data memory, byte lanes share one word decode
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (wr_go && wr_lanes[0]) begin
      mem[wr_idx][7:0] <= wr_data[7:0];
    end
    if (wr_go && wr_lanes[1]) begin
      mem[wr_idx][15:8] <= wr_data[15:8];
    end
  end

  // ****************************************
  // answer and traps, one cycle after the request
  // ****************************************
  wire logic rd_like = is_read || is_pop || is_mac;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rsp_valid        <= 1'b0;
      x_rdata          <= WORD_RESET;
      y_rdata          <= WORD_RESET;
      addr_error_trap  <= 1'b0;
      stack_error_trap <= 1'b0;
    end else begin
      rsp_valid        <= req_valid;
      addr_error_trap  <= misaligned;
      stack_error_trap <= stack_fault;
      if (rd_like) begin
        x_rdata <= next_x;
        y_rdata <= next_y;
      end
    end
  end

endmodule

`default_nettype wire

/* File: bench/data_space_properties.sv */
// port-level assertions for the data-space access unit
`timescale 1ns/100ps
`default_nettype none

module data_space_properties
  import data_space_pkg::*;
#(
  parameter int MEM_WORDS = MEM_WORDS_DEF
)(
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        req_valid,
  input wire op_t         req_op,
  input wire mode_t       req_mode,
  input wire logic        req_byte,
  input wire logic [15:0] req_field,
  input wire logic [15:0] req_wdata,
  input wire logic        rsp_valid,
  input wire logic [15:0] x_rdata,
  input wire logic [15:0] y_rdata,
  input wire logic        addr_error_trap,
  input wire logic        stack_error_trap,
  input wire logic [15:0] stack_limit
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ****
  // helpers
  // ****
  logic limit_set;
  wire logic rw = req_valid && req_op inside {OP_READ, OP_WRITE};
  wire logic rd = req_valid && req_op == OP_READ;
  wire logic [15:0] ram_end = RAM_BASE + 16'(2 * MEM_WORDS - 1);
  always_ff @(posedge core_clk) begin
    if (reset) begin
      limit_set <= 1'b0;
    end else if (req_valid && req_op == OP_LIMIT) begin
      limit_set <= 1'b1;
    end
  end
  sequence s_limit;
    req_valid && req_op == OP_LIMIT;
  endsequence
  sequence s_direct;
    rw && req_mode != MODE_IND;
  endsequence
  // ****
  // properties
  // ****
  a_limit_even: assert property (s_limit |=>
    stack_limit == {$past(req_wdata[15:1]), 1'b0}) else $error("limit value wrong");
  a_limit_holds: assert property (limit_set && !(req_valid && req_op == OP_LIMIT)
    |=> $stable(stack_limit)) else $error("limit changed");
  a_byte_low_lane: assert property (rd && req_byte |=> x_rdata[15:8] == 8'h00)
    else $error("byte read upper not zero");
  a_unimpl_zero: assert property (rd && req_mode == MODE_ABS && !req_byte &&
    !req_field[0] && (req_field < RAM_BASE || req_field > ram_end)
    |=> x_rdata == 16'h0000) else $error("unimplemented read not zero");
  a_misalign_trap: assert property (s_direct and !req_byte
    |=> addr_error_trap == $past(req_field[0])) else $error("alignment trap wrong");
  a_byte_no_trap: assert property (rw && req_byte |=> !addr_error_trap)
    else $error("byte access trapped");
  a_direct_no_stack: assert property (s_direct |=> !stack_error_trap)
    else $error("stack trap on direct access");
  a_idle_quiet: assert property (!req_valid |=>
    !addr_error_trap && !stack_error_trap && !rsp_valid) else $error("event while idle");
  a_y_read_zero: assert property (req_valid && req_op inside {OP_READ, OP_POP}
    |=> y_rdata == 16'h0000) else $error("y path not zero");
endmodule

bind data_space_access_stack_check data_space_properties #(.MEM_WORDS(MEM_WORDS)) u_props (
  .core_clk, .reset, .req_valid, .req_op, .req_mode, .req_byte, .req_field, .req_wdata,
  .rsp_valid, .x_rdata, .y_rdata, .addr_error_trap, .stack_error_trap, .stack_limit);
`default_nettype wire

/* File: bench/core_side_model.sv */
// core-side model issuing requests and working-register writes
`timescale 1ns/100ps
`default_nettype none

module core_side_model
  import data_space_pkg::*;
(
  input  wire logic       core_clk,
  output var logic        req_valid,
  output var op_t         req_op,
  output var mode_t       req_mode,
  output var logic        req_byte,
  output var logic [3:0]  req_ptr,
  output var logic        req_post_inc,
  output var logic [15:0] req_field,
  output var logic [3:0]  req_dest,
  output var logic        req_dest_en,
  output var logic [15:0] req_wdata,
  output var push_kind_t  req_push_kind,
  output var logic        req_x_sel,
  output var logic        req_y_sel,
  output var logic [7:0]  status_low_byte,
  output var logic        reg_we,
  output var logic [3:0]  reg_widx,
  output var logic [15:0] reg_wdata
);
  initial begin
    {req_valid, req_byte, req_post_inc, req_dest_en, reg_we, req_x_sel, req_y_sel} = '0;
    {req_ptr, req_field, req_wdata, reg_widx, reg_wdata} = '0;
    req_dest = 4'h3;
    status_low_byte = 8'h5A;
    req_op = OP_READ;
    req_mode = MODE_ABS;
    req_push_kind = PUSH_PLAIN;
  end
  // one request; returns in the cycle where its answer stands
  task automatic go(input op_t o, input mode_t m, input logic b, input logic [3:0] p,
                    input logic pi, input logic [15:0] a, input logic [15:0] wd,
                    input push_kind_t k);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_op <= o;
    req_mode <= m;
    req_byte <= b;
    req_ptr <= p;
    req_post_inc <= pi;
    req_field <= a;
    req_wdata <= wd;
    req_push_kind <= k;
    req_dest_en <= o inside {OP_READ, OP_POP};
    @(posedge core_clk);
    req_valid <= 1'b0;
    #1;
  endtask
  // register writes only while no request stands
  task automatic wreg(input logic [3:0] i, input logic [15:0] v);
    @(posedge core_clk);
    reg_we <= 1'b1;
    reg_widx <= i;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: bench/data_space_access_stack_check_bench.sv */
// self-checking bench for the data-space access unit
`timescale 1ns/100ps
`default_nettype none

module data_space_access_stack_check_bench
  import data_space_pkg::*;
;
  logic core_clk, reset, req_valid, req_byte, req_post_inc, req_dest_en, reg_we;
  logic req_x_sel, req_y_sel, rsp_valid, addr_error_trap, stack_error_trap;
  logic [3:0] req_ptr, req_dest, reg_widx, reg_ridx;
  logic [7:0] status_low_byte;
  logic [15:0] req_field, req_wdata, reg_wdata, reg_rdata, x_rdata, y_rdata, stack_limit;
  op_t req_op;
  mode_t req_mode;
  push_kind_t req_push_kind;
  logic mod_x_en = 1'b0;
  logic mod_y_en = 1'b0;
  logic req_bitrev = 1'b0;
  logic [15:0] mod_start = 16'h0000;
  logic [15:0] mod_end = 16'h0000;
  wire logic [15:0] traps = {14'h0000, addr_error_trap, stack_error_trap};
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;

  data_space_access_stack_check #(.MEM_WORDS(64)) dut (.*);
  core_side_model u_core (.*);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      wrap_up();
    end
  end
  // ****
  // helpers
  // ****
  task automatic wrap_up;
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_reg(input logic [3:0] i, input logic [15:0] e);
    @(posedge core_clk);
    reg_ridx <= i;
    #1 chk("working register", e, reg_rdata);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic b);
    u_core.go(OP_WRITE, MODE_ABS, b, 4'h0, 1'b0, a, d, PUSH_PLAIN);
  endtask
  task automatic rd(input mode_t m, input logic [15:0] a, input logic b);
    u_core.go(OP_READ, m, b, 4'h0, 1'b0, a, 16'h0000, PUSH_PLAIN);
  endtask
  task automatic stk(input op_t o, input logic [15:0] d, input push_kind_t k);
    u_core.go(o, MODE_IND, 1'b0, SP_IDX, 1'b0, 16'h0000, d, k);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_direct;
    wr(16'h0810, 16'h1357, 1'b0);
    rd(MODE_NEAR, 16'hE810, 1'b0);
    chk("near read", 16'h1357, x_rdata);
    chk("response valid", 16'h0001, {15'h0000, rsp_valid});
    rd(MODE_ABS, 16'h0900, 1'b0);
    chk("unimplemented read", 16'h0000, x_rdata);
  endtask
  task automatic t_bytes;
    wr(16'h0811, 16'hABAB, 1'b1);
    rd(MODE_ABS, 16'h0810, 1'b0);
    chk("byte lane write", 16'hAB57, x_rdata);
    u_core.wreg(4'h3, 16'h5500);
    rd(MODE_ABS, 16'h0811, 1'b1);
    chk("byte read", 16'h00AB, x_rdata);
    chk_reg(4'h3, 16'h55AB);
  endtask
  task automatic t_misalign;
    wr(16'h0811, 16'hFFFF, 1'b0);
    chk("misaligned write trap", 16'h0002, traps);
    rd(MODE_ABS, 16'h0811, 1'b0);
    chk("misaligned read trap", 16'h0002, traps);
    rd(MODE_ABS, 16'h0810, 1'b0);
    chk("suppressed write", 16'hAB57, x_rdata);
  endtask
  task automatic t_post_inc;
    u_core.wreg(4'h1, 16'h0810);
    u_core.go(OP_READ, MODE_IND, 1'b1, 4'h1, 1'b1, 16'h0000, 16'h0000, PUSH_PLAIN);
    chk("indirect byte", 16'h0057, x_rdata);
    chk_reg(4'h1, 16'h0811);
    u_core.go(OP_READ, MODE_IND, 1'b1, 4'h1, 1'b1, 16'h0000, 16'h0000, PUSH_PLAIN);
    chk_reg(4'h1, 16'h0812);
    u_core.go(OP_READ, MODE_IND, 1'b0, 4'h1, 1'b1, 16'h0000, 16'h0000, PUSH_PLAIN);
    chk_reg(4'h1, 16'h0814);
  endtask
  task automatic t_mac(input logic [15:0] xp, input logic [15:0] yp,
                       input logic [15:0] ex, input logic [15:0] ey);
    u_core.wreg(X_PTR_A_IDX, xp);
    u_core.wreg(Y_PTR_A_IDX, yp);
    u_core.go(OP_MAC, MODE_IND, 1'b0, 4'h0, 1'b0, 16'h0000, 16'h0000, PUSH_PLAIN);
    chk("mac x operand", ex, x_rdata);
    chk("mac y operand", ey, y_rdata);
  endtask
  task automatic t_modes;
    u_core.wreg(4'h1, 16'h0802);
    req_bitrev <= 1'b1;
    u_core.go(OP_WRITE, MODE_IND, 1'b0, 4'h1, 1'b0, 16'h0000, 16'h7777, PUSH_PLAIN);
    req_bitrev <= 1'b0;
    rd(MODE_ABS, 16'h0810, 1'b0);
    chk("bit reversed write", 16'h7777, x_rdata);
    mod_x_en <= 1'b1;
    mod_start <= 16'h0840;
    mod_end <= 16'h0843;
    u_core.wreg(4'h1, 16'h0842);
    u_core.go(OP_READ, MODE_IND, 1'b0, 4'h1, 1'b1, 16'h0000, 16'h0000, PUSH_PLAIN);
    chk_reg(4'h1, 16'h0840);
    mod_x_en <= 1'b0;
  endtask
  task automatic t_stack;
    u_core.wreg(SP_IDX, 16'h0820);
    stk(OP_LIMIT, 16'h0823, PUSH_PLAIN);
    chk("limit bit zero", 16'h0822, stack_limit);
    stk(OP_PUSH, 16'h1111, PUSH_PLAIN); // a push, not a stack read, follows the limit
    chk("push below limit", 16'h0000, traps);
    stk(OP_PUSH, 16'hABCD, PUSH_CALL);
    chk("push at limit", 16'h0000, traps);
    stk(OP_PUSH, 16'h1234, PUSH_EXC);
    chk("push past limit", 16'h0001, traps);
    chk_reg(SP_IDX, 16'h0826);
    stk(OP_POP, 16'h0000, PUSH_PLAIN);
    chk("exception frame", 16'h5A34, x_rdata);
    chk_reg(SP_IDX, 16'h0824);
    stk(OP_POP, 16'h0000, PUSH_PLAIN);
    chk("call frame", 16'h00CD, x_rdata);
    u_core.wreg(SP_IDX, 16'h0700);
    stk(OP_PUSH, 16'h0000, PUSH_PLAIN);
    chk("underflow", 16'h0001, traps);
  endtask

  initial begin
    reset = 1'b1;
    reg_ridx = 4'h0;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    t_direct();
    t_bytes();
    t_misalign();
    t_post_inc();
    wr(16'h0860, 16'h2468, 1'b0);
    t_mac(16'h0810, 16'h0860, 16'hAB57, 16'h2468);
    t_mac(16'h0860, 16'h0810, 16'h0000, 16'h0000);
    t_stack();
    t_modes();
    wrap_up();
  end
endmodule
`default_nettype wire
